/* File: core/pin_remap_params.svh */
// Offsets, field positions, reset values and codes of the pin remap block
`ifndef PIN_REMAP_PARAMS_SVH
`define PIN_REMAP_PARAMS_SVH
// Register byte offsets
`define OUT_ROUTE_BASE     8'h00
`define IN_ROUTE_BASE      8'h40
`define PORT_LATCH_OFS     8'h80
`define PORT_DIR_OFS       8'h84
`define STATUS_OFS         8'h88
`define ROUTE_ACTIVE_OFS   8'h8c
// Field positions
`define OUT_FIELD_W        6
`define OUT_FIELD_STEP     8
`define IN_FIELD_W         8
`define STATUS_HV_BIT      0
// Reset values
`define OUT_SEL_RESET      6'h00
`define IN_SEL_RESET       8'h00
`define PORT_LATCH_RESET   32'h0000_0000
`define PORT_DIR_RESET     32'hffff_ffff
// Output select codes
`define SEL_NULL           6'h00
`define SEL_SERIAL_TX_ONE  6'h01
`define SEL_SERIAL_TX_TWO  6'h03
`define SEL_SPI_TWO_DATA   6'h08
`define SEL_SPI_TWO_CLOCK  6'h09
`define SEL_SPI_TWO_SELECT 6'h0a
`define SEL_CAN_ONE_TX     6'h0e
`define SEL_COMPARE_ONE    6'h10
`define SEL_COMPARE_TWO    6'h11
`define SEL_COMPARE_THREE  6'h12
`define SEL_COMPARE_FOUR   6'h13
`define SEL_CMP_ONE        6'h18
`define SEL_CMP_TWO        6'h19
`define SEL_CMP_THREE      6'h1a
`define SEL_PWM_SYNC       6'h2d
`define SEL_REF_CLOCK      6'h31
`define SEL_CMP_FOUR       6'h32
`define SEL_CMP_FIVE       6'h33
`define SEL_NIBBLE_ONE     6'h39
`define SEL_NIBBLE_TWO     6'h3a
// Input select codes
`define IN_VIRT_FIRST      8'hb0
`define IN_VIRT_LAST       8'hb5
`define IN_IMPL_MASK       128'hf3c00003_c0000160_b7ffffff_1b1f101e
`endif

/* File: core/pin_remap_pkg.sv */
// Types shared by the pin remap block
package pin_remap_pkg;
	// Levels of all remappable peripheral outputs
	typedef struct packed {
		logic serial_tx_one, serial_tx_two;
		logic spi_two_data_out, spi_two_clock_out, spi_two_select_out;
		logic can_one_transmit;
		logic compare_out_one, compare_out_two;
		logic compare_out_three, compare_out_four;
		logic comparator_one_out, comparator_two_out, comparator_three_out;
		logic comparator_four_out, comparator_five_out;
		logic pwm_timebase_sync_out, reference_clock_out;
		logic nibble_link_tx_one, nibble_link_tx_two;
	} periph_out_t;
	// Outcome of one pin's output route code
	typedef struct packed {
		logic active;
		logic level;
	} route_pick_t;
	// Outcome of one peripheral input route code
	typedef struct packed {
		logic valid;
		logic level;
	} input_pick_t;
endpackage : pin_remap_pkg

/* File: core/pin_out_select.sv */
// Output route decoder for one remappable pin
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_params.svh"
module pin_out_select (
	// Route code and peripheral outputs
	input  wire logic [5:0]                 sel,
	input  wire pin_remap_pkg::periph_out_t po,
	// Chosen output
	output pin_remap_pkg::route_pick_t      pick
);
	// Pick one peripheral output by code
	always_comb begin
		pick.active = 1'b1;
		unique case (sel)
			`SEL_SERIAL_TX_ONE:  pick.level = po.serial_tx_one; // R3
			`SEL_SERIAL_TX_TWO:  pick.level = po.serial_tx_two; // R3
			`SEL_SPI_TWO_DATA:   pick.level = po.spi_two_data_out; // R4
			`SEL_SPI_TWO_CLOCK:  pick.level = po.spi_two_clock_out; // R4
			`SEL_SPI_TWO_SELECT: pick.level = po.spi_two_select_out; // R4
			`SEL_CAN_ONE_TX:     pick.level = po.can_one_transmit; // R5
			`SEL_COMPARE_ONE:    pick.level = po.compare_out_one; // R6
			`SEL_COMPARE_TWO:    pick.level = po.compare_out_two; // R6
			`SEL_COMPARE_THREE:  pick.level = po.compare_out_three; // R6
			`SEL_COMPARE_FOUR:   pick.level = po.compare_out_four; // R6
			`SEL_CMP_ONE:        pick.level = po.comparator_one_out; // R7
			`SEL_CMP_TWO:        pick.level = po.comparator_two_out; // R7
			`SEL_CMP_THREE:      pick.level = po.comparator_three_out; // R7
			`SEL_CMP_FOUR:       pick.level = po.comparator_four_out; // R8
			`SEL_CMP_FIVE:       pick.level = po.comparator_five_out; // R8
			`SEL_PWM_SYNC:       pick.level = po.pwm_timebase_sync_out; // R9
			`SEL_REF_CLOCK:      pick.level = po.reference_clock_out; // R9
			`SEL_NIBBLE_ONE:     pick.level = po.nibble_link_tx_one; // R10
			`SEL_NIBBLE_TWO:     pick.level = po.nibble_link_tx_two; // R10
			default: begin
				// Null and unassigned codes leave the port in charge
				pick.active = 1'b0; // R19
				pick.level  = 1'b0;
			end
		endcase
	end
endmodule : pin_out_select
`default_nettype wire

/* File: core/input_select_decode.sv */
// Input route decoder: one code picks one pad or virtual pin
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_params.svh"
module input_select_decode (
	// Route code
	input  wire logic [7:0]            code,
	// Candidate levels
	input  wire logic [127:0]          pad_level,
	input  wire logic [5:0]            virt_level,
	// Chosen level
	output pin_remap_pkg::input_pick_t pick
);
	localparam logic [127:0] IMPL = `IN_IMPL_MASK;

	// Pads by number, virtual pins in their band, all else no pin
	always_comb begin
		pick = '0;
		if (!code[7]) begin
			pick.valid = IMPL[code[6:0]]; // R12
			pick.level = IMPL[code[6:0]] & pad_level[code[6:0]]; // R14
		end else if (code >= `IN_VIRT_FIRST && code <= `IN_VIRT_LAST) begin
			pick.valid = 1'b1; // R13
			pick.level = virt_level[code[2:0]]; // R13
		end
	end
endmodule : input_select_decode
`default_nettype wire

/* File: core/peripheral_pin_remap.sv */
// Remappable pin multiplexer with APB register access
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pin_remap_params.svh"

// How it works
// R1: Each remappable pin has its own 6-bit code choosing one peripheral output.
// R2: Every pin output code resets to zero, leaving the default port function.
// R3: Code 01 drives serial transmitter one, code 03 serial transmitter two.
// R4: Codes 08, 09, 0a drive SPI two data, clock and select outputs.
// R5: Code 0e drives the first CAN controller transmit output.
// R6: Codes 10 to 13 drive output compare units one to four.
// R7: Codes 18, 19, 1a drive comparators one, two and three.
// R8: Codes 32 and 33 drive comparators four and five.
// R9: Code 2d drives PWM time base sync, code 31 the reference clock.
// R10: Codes 39 and 3a drive nibble link transmitters one and two.
// R11: No interlocks; any mapping combination across pins is accepted.
// R12: Input codes below 80 hex select the pad of that number.
// R13: Input codes b0 to b5 select virtual pins 176 to 181.
// R14: Unimplemented input codes select no pin; the input reads low.
// R15: Overvoltage on the core supply tri-states every pin; here only while ce is high, as a low ce freezes the pins as they are.
// R16: Tri-state holds while overvoltage stays, with no software override.
// R17: A dedicated output enabled on a pin beats any remapped output.
// R18: Active remapped or dedicated outputs drive regardless of direction.
// R19: Unassigned output codes behave like the null code.
// R20: Software avoids mapping outputs onto externally tied pins.
module peripheral_pin_remap #(
	parameter int NUM_PINS   = 8,
	parameter int NUM_INPUTS = 4
) (
	// Clock, reset, enable
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	// APB slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// Peripheral outputs to route
	input  wire pin_remap_pkg::periph_out_t periph_out,
	input  wire logic [NUM_PINS-1:0]        dedicated_enable,
	input  wire logic [NUM_PINS-1:0]        dedicated_level,
	// Peripheral inputs fed from pins
	output logic [NUM_INPUTS-1:0]           periph_in,
	// Pin side
	input  wire logic [127:0]               pad_level,
	input  wire logic [5:0]                 virt_level,
	output logic [NUM_PINS-1:0]             pin_out,
	output logic [NUM_PINS-1:0]             pin_oe_n,
	// Supply monitor
	input  wire logic                       core_overvoltage_detect
);
	// ***********************************************************
	// Sizes and checks
	// ***********************************************************
	localparam int NUM_OUT_REGS = NUM_PINS / 2;

	// Refuse sizes the register map cannot hold
	if (NUM_PINS < 2 || NUM_PINS > 32 || (NUM_PINS % 2) != 0) begin : g_bad_pins
		$error("NUM_PINS must be even and between 2 and 32");
	end
	if (NUM_INPUTS < 1 || NUM_INPUTS > 16) begin : g_bad_inputs
		$error("NUM_INPUTS must be between 1 and 16");
	end

	// ***********************************************************
	// State
	// ***********************************************************
	typedef struct packed {
		logic [NUM_PINS-1:0][5:0]   out_sel;
		logic [NUM_INPUTS-1:0][7:0] in_sel;
		logic [NUM_PINS-1:0]        latch;
		logic [NUM_PINS-1:0]        dir;
		logic [NUM_PINS-1:0]        pin_out;
		logic [NUM_PINS-1:0]        pin_oe_n;
		logic [NUM_PINS-1:0]        route_active;
		logic [NUM_INPUTS-1:0]      periph_in;
		logic                       hv;
		logic                       pready;
		logic                       pslverr;
		logic [31:0]                prdata;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// ***********************************************************
	// Route decoders
	// ***********************************************************
	pin_remap_pkg::route_pick_t out_pick [NUM_PINS];
	pin_remap_pkg::input_pick_t in_pick [NUM_INPUTS];

	// One output decoder per pin
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_out
		pin_out_select u_sel (
			.sel  (st_reg.out_sel[p]), // R1
			.po   (periph_out),
			.pick (out_pick[p])
		);
	end

	// One input decoder per peripheral input
	for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_in
		input_select_decode u_dec (
			.code       (st_reg.in_sel[i]),
			.pad_level  (pad_level),
			.virt_level (virt_level),
			.pick       (in_pick[i])
		);
	end

	// ***********************************************************
	// Address decode
	// ***********************************************************
	logic       access;
	logic       commit;
	logic       aligned;
	logic       out_hit;
	logic       in_hit;
	logic       latch_hit;
	logic       dir_hit;
	logic       status_hit;
	logic       active_hit;
	logic       mapped;
	logic [3:0] word_idx;

	// Region and word index from the byte address
	always_comb begin
		access     = psel & penable;
		commit     = access & st_reg.pready;
		aligned    = (paddr[1:0] == 2'h0);
		word_idx   = paddr[5:2];
		out_hit    = aligned && paddr[7:6] == 2'(`OUT_ROUTE_BASE >> 6)
			&& 32'(word_idx) < NUM_OUT_REGS;
		in_hit     = aligned && paddr[7:6] == 2'(`IN_ROUTE_BASE >> 6)
			&& 32'(word_idx) < NUM_INPUTS;
		latch_hit  = (paddr == `PORT_LATCH_OFS);
		dir_hit    = (paddr == `PORT_DIR_OFS);
		status_hit = (paddr == `STATUS_OFS);
		active_hit = (paddr == `ROUTE_ACTIVE_OFS);
		mapped     = out_hit | in_hit | latch_hit | dir_hit
			| status_hit | active_hit;
	end

	// ***********************************************************
	// Read data
	// ***********************************************************
	logic [31:0] rd_word;

	// Mux the addressed register onto a zero-filled word
	always_comb begin
		rd_word = 32'h0000_0000;
		if (out_hit) begin
			for (int f = 0; f < 2; f++) begin
				rd_word[f*`OUT_FIELD_STEP +: `OUT_FIELD_W] =
					st_reg.out_sel[2*word_idx+f];
			end
		end else if (in_hit) begin
			rd_word[`IN_FIELD_W-1:0] = st_reg.in_sel[word_idx];
		end else if (latch_hit) begin
			rd_word[NUM_PINS-1:0] = st_reg.latch;
		end else if (dir_hit) begin
			rd_word[NUM_PINS-1:0] = st_reg.dir;
		end else if (status_hit) begin
			rd_word[`STATUS_HV_BIT] = st_reg.hv;
		end else if (active_hit) begin
			rd_word[NUM_PINS-1:0] = st_reg.route_active;
		end
	end

	// ***********************************************************
	// Next state
	// ***********************************************************
	always_comb begin
		st_next = st_reg;

		// Bus answer: one wait cycle, then a one-cycle ready
		st_next.pready = 1'b0;
		if (access && !st_reg.pready) begin
			st_next.pready  = 1'b1;
			st_next.pslverr = ~mapped;
			st_next.prdata  = pwrite ? 32'h0000_0000 : rd_word;
		end else begin
			st_next.pslverr = 1'b0;
			st_next.prdata  = 32'h0000_0000;
		end

		// Writes land at the completing edge, any value accepted
		if (commit && pwrite) begin
			if (out_hit) begin
				for (int f = 0; f < 2; f++) begin
					st_next.out_sel[2*word_idx+f] = // R11
						pwdata[f*`OUT_FIELD_STEP +: `OUT_FIELD_W];
				end
			end
			if (in_hit) begin
				st_next.in_sel[word_idx] = pwdata[`IN_FIELD_W-1:0]; // R11
			end
			if (latch_hit) begin
				st_next.latch = pwdata[NUM_PINS-1:0];
			end
			if (dir_hit) begin
				st_next.dir = pwdata[NUM_PINS-1:0];
			end
		end

		// Supply monitor level, sampled each cycle that ce is high
		st_next.hv = core_overvoltage_detect;

		// Pin drive with its priority order
		for (int p = 0; p < NUM_PINS; p++) begin
			st_next.route_active[p] = out_pick[p].active;
			if (core_overvoltage_detect) begin
				// Only the low-enable freeze below overrides the forced tri-state
				st_next.pin_oe_n[p] = 1'b1; // R15 R16
				st_next.pin_out[p]  = 1'b0;
			end else if (dedicated_enable[p]) begin
				st_next.pin_oe_n[p] = 1'b0; // R17 R18
				st_next.pin_out[p]  = dedicated_level[p];
			end else if (out_pick[p].active) begin
				st_next.pin_oe_n[p] = 1'b0; // R18
				st_next.pin_out[p]  = out_pick[p].level;
			end else begin
				// Default port: direction low drives the latch
				st_next.pin_oe_n[p] = st_reg.dir[p]; // R19
				st_next.pin_out[p]  = st_reg.latch[p] & ~st_reg.dir[p];
			end
		end

		// Peripheral inputs; no pin reads as low
		for (int i = 0; i < NUM_INPUTS; i++) begin
			st_next.periph_in[i] = in_pick[i].valid // R14
				& in_pick[i].level;
		end

		// Low enable freezes everything
		if (!ce) begin
			st_next = st_reg;
		end
	end

	// ***********************************************************
	// State register
	// ***********************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg          <= '0;
			st_reg.out_sel  <= {NUM_PINS{`OUT_SEL_RESET}}; // R2
			st_reg.in_sel   <= {NUM_INPUTS{`IN_SEL_RESET}};
			st_reg.latch    <= NUM_PINS'(`PORT_LATCH_RESET);
			st_reg.dir      <= NUM_PINS'(`PORT_DIR_RESET);
			st_reg.pin_oe_n <= {NUM_PINS{1'b1}};
		end else begin
			st_reg <= st_next;
		end
	end

	// ***********************************************************
	// Outputs
	// ***********************************************************
	// All outputs straight from the state register
	assign prdata    = st_reg.prdata;
	assign pready    = st_reg.pready;
	assign pslverr   = st_reg.pslverr;
	assign pin_out   = st_reg.pin_out;
	assign pin_oe_n  = st_reg.pin_oe_n;
	assign periph_in = st_reg.periph_in;

endmodule : peripheral_pin_remap
`default_nettype wire

/* File: tb/pin_remap_monitor.sv */
// Bus and pin checks for the pin remap block
`timescale 1ns/1ps
`default_nettype none
module pin_remap_monitor #(
	parameter int NUM_PINS   = 8,
	parameter int NUM_INPUTS = 4
) (
	// Clock and control
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                ce,
	// APB
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// Pins
	input wire logic [NUM_PINS-1:0] dedicated_enable,
	input wire logic [NUM_PINS-1:0] dedicated_level,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe_n,
	input wire logic                core_overvoltage_detect
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase still waiting for its answer
	sequence access_s;
		ce && psel && penable && !pready;
	endsequence
	// Supply too high on an enabled edge
	sequence hv_s;
		ce && core_overvoltage_detect;
	endsequence
	one_wait_a: assert property (access_s |=> pready)
		else $error("no answer after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	idle_quiet_a: assert property (ce && !psel |=> !pready && prdata == 32'h0)
		else $error("answer without request");
	bad_addr_a: assert property
		(access_s ##0 paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
		else $error("unaligned access not refused");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error outside answer cycle");
	hv_tristate_a: assert property (hv_s |=> pin_oe_n == '1 && pin_out == '0)
		else $error("pins driven during overvoltage");
	hv_persist_a: assert property (hv_s ##1 hv_s |-> pin_oe_n == '1)
		else $error("tristate released during overvoltage");
	dedicated_a: assert property (ce && !core_overvoltage_detect |=>
		(pin_oe_n & $past(dedicated_enable)) == '0 &&
		((pin_out ^ $past(dedicated_level)) & $past(dedicated_enable)) == '0)
		else $error("dedicated output not driven");
	freeze_a: assert property (!ce |=> $stable(pin_out) && $stable(pin_oe_n))
		else $error("pins moved while disabled");
endmodule : pin_remap_monitor
bind peripheral_pin_remap pin_remap_monitor #(.NUM_PINS(NUM_PINS),
	.NUM_INPUTS(NUM_INPUTS)) pin_remap_monitor_i (.pclk(pclk),
	.presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dedicated_enable(dedicated_enable), .dedicated_level(dedicated_level),
	.pin_out(pin_out), .pin_oe_n(pin_oe_n),
	.core_overvoltage_detect(core_overvoltage_detect));
`default_nettype wire

/* File: tb/pin_side_model.sv */
// Far-side model: peripheral output levels and pad levels
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
	// Stimulus controls
	input  wire logic [4:0]            hot,
	input  wire logic                  inv,
	input  wire logic [7:0]            spot,
	input  wire logic                  lvl,
	// Levels seen by the remap block
	output pin_remap_pkg::periph_out_t periph_out,
	output logic [127:0]               pad_level,
	output logic [5:0]                 virt_level
);
	// One peripheral differs from all others, so a wrong pick shows
	assign periph_out = pin_remap_pkg::periph_out_t'((19'h1 << hot) ^ {19{inv}});
	// Only the spot pin carries lvl, every other pin the opposite
	always_comb begin
		for (int i = 0; i < 128; i++) begin
			pad_level[i] = lvl ^ (i != spot);
		end
		for (int j = 0; j < 6; j++) begin
			virt_level[j] = lvl ^ ((j + 176) != spot);
		end
	end
endmodule : pin_side_model
`default_nettype wire

/* File: tb/peripheral_pin_remap_tb.sv */
// Self-checking testbench of the pin remap block
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_remap_tb;
	logic                       pclk = 1'b0;
	logic                       presetn, ce, psel, penable, pwrite, e;
	logic                       overvoltage, inv, lvl;
	logic [7:0]                 paddr, spot, dedicated_enable;
	logic [7:0]                 dedicated_level, pin_out, pin_oe_n;
	logic [31:0]                pwdata, prdata, q;
	logic                       pready, pslverr;
	logic [4:0]                 hot;
	logic [3:0]                 periph_in;
	logic [127:0]               pad_level;
	logic [5:0]                 virt_level;
	pin_remap_pkg::periph_out_t periph_out;
	int                         fails, num_checks;
	// Codes in the order of the peripheral output struct
	localparam logic [5:0] out_codes [19] = '{6'h01, 6'h03, 6'h08, 6'h09,
		6'h0a, 6'h0e, 6'h10, 6'h11, 6'h12, 6'h13, 6'h18, 6'h19, 6'h1a,
		6'h32, 6'h33, 6'h2d, 6'h31, 6'h39, 6'h3a};
	localparam logic [5:0] spare_codes [2] = '{6'h02, 6'h3f};
	localparam logic [7:0] in_codes [7] = '{8'h31, 8'h60, 8'h7f, 8'hb0,
		8'hb5, 8'h62, 8'h73};
	localparam logic in_ok [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	localparam logic [7:0] bad_addr [2] = '{8'h90, 8'h02};

	peripheral_pin_remap #(.NUM_PINS(8), .NUM_INPUTS(4)) peripheral_pin_remap_i (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periph_out(periph_out), .dedicated_enable(dedicated_enable),
		.dedicated_level(dedicated_level), .periph_in(periph_in),
		.pad_level(pad_level), .virt_level(virt_level), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .core_overvoltage_detect(overvoltage));
	pin_side_model pin_side_model_i (.hot(hot), .inv(inv), .spot(spot),
		.lvl(lvl), .periph_out(periph_out), .pad_level(pad_level),
		.virt_level(virt_level));

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	task print_verdict;
		if (fails == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : print_verdict

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk

	// One APB transfer, then one idle cycle
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (n == 20) begin
			fails++;
			$display("unexpected at %0t: bus timeout", $time);
			print_verdict();
		end
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x, "read");
	endtask : rd

	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, overvoltage, inv, lvl} = '0;
		{paddr, pwdata, spot, hot, dedicated_enable, dedicated_level} = '0;
		{fails, num_checks} = '0;
		ce = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 4; k++) rd(8'(4 * k), 32'h0);
		rd(8'h84, 32'h0000_00ff);
		chk(32'(pin_oe_n), 32'hff, "reset pins");
		// Every output code on pin 1, pin 0 stays released
		for (int i = 0; i < 19; i++) begin
			wr(8'h00, {18'h0, out_codes[i], 8'h00});
			hot <= 5'(18 - i);
			inv <= 1'b0;
			repeat (2) @(posedge pclk);
			chk({pin_oe_n[0], pin_out[1], pin_oe_n[1]}, 32'h6, "hi");
			inv <= 1'b1;
			repeat (2) @(posedge pclk);
			chk({pin_oe_n[0], pin_out[1], pin_oe_n[1]}, 32'h4, "lo");
		end
		// Spare codes fall back to the port latch
		wr(8'h84, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(8'h00, {18'h0, spare_codes[i], 8'h00});
			repeat (2) @(posedge pclk);
			chk({pin_out[1], pin_oe_n[1]}, 32'h0, "spare");
		end
		// Same output on every pin; the model ties no pins together
		for (int k = 0; k < 4; k++) wr(8'(4 * k), 32'h0101);
		hot <= 5'd18;
		inv <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({pin_out, pin_oe_n}, 32'hff00, "fan out");
		rd(8'h0c, 32'h0000_0101);
		rd(8'h8c, 32'h0000_00ff);
		dedicated_enable <= 8'h01;
		repeat (2) @(posedge pclk);
		chk({pin_out, pin_oe_n}, 32'hfe00, "dedicated");
		overvoltage <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({pin_out, pin_oe_n}, 32'h00ff, "overvoltage");
		wr(8'h00, 32'h0101);
		wr(8'h84, 32'h0);
		chk({pin_out, pin_oe_n}, 32'h00ff, "override");
		rd(8'h88, 32'h0000_0001);
		overvoltage <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({pin_out, pin_oe_n}, 32'hfe00, "recovered");
		ce <= 1'b0;
		inv <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({pin_out, pin_oe_n}, 32'hfe00, "frozen");
		ce <= 1'b1;
		// Input codes: pads, virtual pins, unimplemented
		lvl <= 1'b1;
		for (int j = 0; j < 7; j++) begin
			wr(8'h40, {24'h0, in_codes[j]});
			spot <= in_codes[j];
			repeat (2) @(posedge pclk);
			chk(32'(periph_in), {31'h0, in_ok[j]}, "input");
		end
		// Unmapped and unaligned addresses are refused
		for (int j = 0; j < 2; j++) begin
			apb(1'b0, bad_addr[j], 32'h0);
			chk({q[30:0], e}, 32'h1, "refused");
		end
		print_verdict();
	end
endmodule : peripheral_pin_remap_tb
`default_nettype wire
